// *** timer16_cfg.svh ***
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH
// APB byte addresses
`define T16_CTRL_A_ADDR   12'h000
`define T16_CTRL_B_ADDR   12'h004
`define T16_CMP_A_ADDR    12'h008
`define T16_CMP_B_ADDR    12'h00C
`define T16_CAPT_ADDR     12'h010
`define T16_COUNT_ADDR    12'h014
`define T16_STATUS_ADDR   12'h018
`define T16_MASK_ADDR     12'h01C
`define T16_PORT_ADDR     12'h020
// Field positions
`define T16_COM_A_HI      7
`define T16_COM_A_LO      6
`define T16_COM_B_HI      5
`define T16_COM_B_LO      4
`define T16_CTRL_A_MASK   8'hF3
`define T16_CTRL_B_MASK   8'h1F
`define T16_CTRL_RESET    8'h00
// Status bits
`define T16_ST_OVF        0
`define T16_ST_CMPA       1
`define T16_ST_CMPB       2
// Counter limits
`define T16_MAX           16'hFFFF
`define T16_TOP8          16'h00FF
`define T16_TOP9          16'h01FF
`define T16_TOP10         16'h03FF
`define T16_BOTTOM        16'h0000
`endif

// *** timer16_pkg.sv ***
package timer16_pkg;
  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic a;
    logic b;
  } wave_pair_t;

  typedef enum logic [2:0] {
    SEQ_UP   = 3'b001,
    SEQ_FAST = 3'b010,
    SEQ_DUAL = 3'b100
  } seq_kind_t;
endpackage : timer16_pkg

// *** timer16_waveform_mode_control.sv ***
`timescale 1ns/1ps
`include "timer16_cfg.svh"
// Behaviour
// - All logic on pclk; timer tick acts only as a clock enable
// - Control A: chan A mode 7:6, chan B mode 5:4, low mode bits 1:0
// - Nonzero output mode connects wave output, except toggle code outside its modes; pin driven only if direction is output
// - Normal/CLEAR_ON_MATCH_MODE: 00 off, 01 toggle, 10 clear, 11 set on match
// - Fast PWM mode 01: A toggles only in modes 14/15, B disconnected
// - Fast PWM: 10 clears on match sets at TOP; 11 the inverse
// - Fast PWM: compare equal TOP with upper bit set ignores match, TOP action only
// - Dual slope mode 01: A toggles only in modes 8-11, B disconnected
// - Four-bit mode selects sequence, TOP source, waveform; code 13 reserved
// - Modes 0/4/12: TOP fixed/compare A/capture, immediate update, overflow at MAX
// - Modes 1-3,10,11: dual slope, update at TOP, overflow at BOTTOM
// - Modes 8/9: TOP capture/compare A, update and overflow at BOTTOM
// - Modes 5-7,14,15: fast PWM, update and overflow at TOP
// - Clock select: stop, divide 1/8/64/256/1024, external falling/rising edge
module timer16_waveform_mode_control (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External count pin
  input  wire logic        ext_clk_pin,
  // Waveform pins
  output logic             wave_out_a,
  output logic             wave_out_a_oe,
  output logic             wave_out_b,
  output logic             wave_out_b_oe,
  // Interrupt
  output logic             irq
);
  // ==========================================================================
  // Registers
  logic [7:0]  ctrl_a_q, ctrl_b_q;
  logic [15:0] cmp_a_q, cmp_b_q, cmp_a_buf_q, cmp_b_buf_q, capt_q, count_q;
  logic [2:0]  status_q, mask_q;
  logic [3:0]  port_q;
  logic        down_q;
  logic [9:0]  pre_q;
  logic [2:0]  ext_sync_q;
  timer16_pkg::wave_pair_t wave_q;
  timer16_pkg::wave_pair_t wave_pin_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q, irq_q, oe_a_q, oe_b_q;

  // ==========================================================================
  // Bus decode
  wire        acc_en  = psel && penable && !pready_q;
  wire        wr_en   = acc_en && pwrite;
  wire        hit     = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00)
                        && (paddr[5:2] <= 4'h8);
  wire        wr_ca   = wr_en && paddr == `T16_CTRL_A_ADDR;
  wire        wr_cb   = wr_en && paddr == `T16_CTRL_B_ADDR;
  wire        wr_ma   = wr_en && paddr == `T16_CMP_A_ADDR;
  wire        wr_mb   = wr_en && paddr == `T16_CMP_B_ADDR;
  wire        wr_cap  = wr_en && paddr == `T16_CAPT_ADDR;
  wire        wr_cnt  = wr_en && paddr == `T16_COUNT_ADDR;
  wire        wr_st   = wr_en && paddr == `T16_STATUS_ADDR;
  wire        wr_mk   = wr_en && paddr == `T16_MASK_ADDR;
  wire        wr_pt   = wr_en && paddr == `T16_PORT_ADDR;

  // ==========================================================================
  // Mode decode
  // mode field
  wire [3:0]  mode    = {ctrl_b_q[4:3], ctrl_a_q[1:0]};
  wire [1:0]  com_a   = ctrl_a_q[`T16_COM_A_HI:`T16_COM_A_LO];
  wire [1:0]  com_b   = ctrl_a_q[`T16_COM_B_HI:`T16_COM_B_LO];
  wire [2:0]  cs      = ctrl_b_q[2:0];

  function automatic timer16_pkg::seq_kind_t seq_of(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: seq_of = timer16_pkg::SEQ_DUAL;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF:             seq_of = timer16_pkg::SEQ_FAST;
      default:                                  seq_of = timer16_pkg::SEQ_UP;
    endcase
  endfunction : seq_of

  wire timer16_pkg::seq_kind_t kind = seq_of(mode);
  wire        is_fast = kind == timer16_pkg::SEQ_FAST;
  wire        is_dual = kind == timer16_pkg::SEQ_DUAL;
  wire        is_up   = kind == timer16_pkg::SEQ_UP;
  wire        pfc     = mode == 4'h8 || mode == 4'h9;
  // reserved code counts as normal with no waveform
  wire        resv    = mode == 4'hD;

  logic [15:0] top;
  always_comb begin
    case (mode)
      4'h1, 4'h5: top = `T16_TOP8;
      4'h2, 4'h6: top = `T16_TOP9;
      4'h3, 4'h7: top = `T16_TOP10;
      4'h4, 4'h9, 4'hB, 4'hF: top = cmp_a_q;
      4'h8, 4'hA, 4'hC, 4'hE: top = capt_q;
      default: top = `T16_MAX;
    endcase
  end

  // ==========================================================================
  // Prescaler and tick
  // clock source
  wire ext_rise = ext_sync_q[1] && !ext_sync_q[2];
  wire ext_fall = !ext_sync_q[1] && ext_sync_q[2];
  logic tick;
  always_comb begin
    case (cs)
      3'h1: tick = 1'b1;
      3'h2: tick = pre_q[2:0] == 3'h7;
      3'h3: tick = pre_q[5:0] == 6'h3F;
      3'h4: tick = pre_q[7:0] == 8'hFF;
      3'h5: tick = pre_q == 10'h3FF;
      3'h6: tick = ext_fall;
      3'h7: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // ==========================================================================
  // Counter events
  wire at_top    = count_q == top;
  wire at_bottom = count_q == `T16_BOTTOM;
  wire up_dir    = is_dual ? !down_q : 1'b1;
  wire upd_pt    = is_up || (is_fast && at_top) || (is_dual && !pfc && at_top)
                   || (pfc && at_bottom);
  wire ovf_ev    = is_up ? count_q == `T16_MAX
                 : is_fast ? at_top : (at_bottom && down_q);
  wire [1:0] match = {count_q == cmp_b_q, count_q == cmp_a_q};
  logic [15:0] count_d;
  logic        down_d;
  always_comb begin
    count_d = count_q + 16'h0001;
    down_d  = down_q;
    if (is_dual) begin
      if (at_top && !down_q) down_d = 1'b1;
      else if (at_bottom && down_q) down_d = 1'b0;
      count_d = down_d ? count_q - 16'h0001 : count_q + 16'h0001;
    end else if (at_top) begin
      count_d = `T16_BOTTOM;
    end
  end

  // ==========================================================================
  // Waveform actions
  // per-channel next level
  function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                     input logic m, input logic up, input logic tp,
                                     input logic chan_a);
    logic pwm_m;
    pwm_m = m && !(is_fast && tp && com[1]);
    wave_next = cur;
    if (resv || com == 2'b00) wave_next = cur;
    else if (com == 2'b01) begin
      if (is_up || (chan_a && is_fast && mode[3]) || (chan_a && is_dual && mode[3]))
        wave_next = m ? !cur : cur;
    end else if (is_up) wave_next = m ? com[0] : cur;
    else if (is_fast) begin
      if (tp) wave_next = !com[0];
      if (pwm_m) wave_next = com[0];
    end else if (m) wave_next = up ? com[0] : !com[0];
  endfunction : wave_next

  // ==========================================================================
  // Sequential
  // pclk only, tick enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 16'h0000;
      down_q  <= 1'b0;
      wave_q  <= '0;
      status_q <= 3'h0;
    end else begin
      if (wr_cnt) count_q <= pwdata[15:0];
      else if (tick) begin
        count_q <= count_d;
        down_q  <= down_d;
        wave_q.a <= wave_next(wave_q.a, com_a, match[0], up_dir, at_top, 1'b1);
        wave_q.b <= wave_next(wave_q.b, com_b, match[1], up_dir, at_top, 1'b0);
      end
      // Set wins over write-one-to-clear
      status_q <= (status_q & ~({3{wr_st}} & pwdata[2:0]))
                  | ({3{tick}} & {match[1], match[0], ovf_ev});
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q <= `T16_CTRL_RESET;
      ctrl_b_q <= `T16_CTRL_RESET;
      cmp_a_buf_q <= 16'h0000;
      cmp_b_buf_q <= 16'h0000;
      cmp_a_q  <= 16'h0000;
      cmp_b_q  <= 16'h0000;
      capt_q   <= 16'h0000;
      mask_q   <= 3'h0;
      port_q   <= 4'h0;
    end else begin
      // control A layout, bits 3:2 dropped
      if (wr_ca) ctrl_a_q <= pwdata[7:0] & `T16_CTRL_A_MASK;
      if (wr_cb) ctrl_b_q <= pwdata[7:0] & `T16_CTRL_B_MASK;
      if (wr_ma) cmp_a_buf_q <= pwdata[15:0];
      if (wr_mb) cmp_b_buf_q <= pwdata[15:0];
      if (wr_cap) capt_q <= pwdata[15:0];
      if (wr_mk) mask_q <= pwdata[2:0];
      if (wr_pt) port_q <= pwdata[3:0];
      if (is_up || (tick && upd_pt)) begin
        cmp_a_q <= cmp_a_buf_q;
        cmp_b_q <= cmp_b_buf_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q      <= 10'h000;
      ext_sync_q <= 3'h0;
    end else begin
      pre_q      <= (cs == 3'h0) ? 10'h000 : pre_q + 10'h001;
      ext_sync_q <= {ext_sync_q[1:0], ext_clk_pin};
    end
  end

  // ==========================================================================
  // Bus answer and pins
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      `T16_CTRL_A_ADDR: rd_mux = {24'h0, ctrl_a_q};
      `T16_CTRL_B_ADDR: rd_mux = {24'h0, ctrl_b_q};
      `T16_CMP_A_ADDR:  rd_mux = {16'h0, cmp_a_buf_q};
      `T16_CMP_B_ADDR:  rd_mux = {16'h0, cmp_b_buf_q};
      `T16_CAPT_ADDR:   rd_mux = {16'h0, capt_q};
      `T16_COUNT_ADDR:  rd_mux = {16'h0, count_q};
      `T16_STATUS_ADDR: rd_mux = {29'h0, status_q};
      `T16_MASK_ADDR:   rd_mux = {29'h0, mask_q};
      `T16_PORT_ADDR:   rd_mux = {28'h0, port_q};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // toggle code disconnects outside its modes
  wire own_a = com_a[1] || (com_a[0] && (is_up || mode[3]));
  wire own_b = com_b[1] || (com_b[0] && is_up);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 1'b0;
      oe_a_q    <= 1'b0;
      oe_b_q    <= 1'b0;
      wave_pin_q <= '0;
    end else begin
      pready_q  <= acc_en;
      pslverr_q <= acc_en && !hit;
      prdata_q  <= (acc_en && !pwrite) ? rd_mux : 32'h0000_0000;
      irq_q     <= |(status_q & mask_q);
      oe_a_q    <= port_q[2];
      oe_b_q    <= port_q[3];
      wave_pin_q.a <= own_a ? wave_q.a : port_q[0];
      wave_pin_q.b <= own_b ? wave_q.b : port_q[1];
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign irq           = irq_q;
  assign wave_out_a    = wave_pin_q.a;
  assign wave_out_b    = wave_pin_q.b;
  assign wave_out_a_oe = oe_a_q;
  assign wave_out_b_oe = oe_b_q;

  // ==========================================================================
  // Assertions
  reserved_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_a_q[3:2] == 2'b00) else $error("ctrl A reserved bits set");
  fast_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && is_fast && at_top && !wr_cnt |=> count_q == 16'h0000)
    else $error("fast pwm did not wrap");
  dual_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && is_dual && at_top && !down_q && !wr_cnt && top != 16'h0000 |=> down_q)
    else $error("dual slope did not turn");
  ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && is_up && count_q == 16'hFFFF |=> status_q[0])
    else $error("overflow not set at max");
  stop_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    cs == 3'h0 && !wr_cnt |=> $stable(count_q)) else $error("counter ran while stopped");
  ctc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && is_up && !resv && com_a == 2'b10 && match[0] && !wr_cnt |=> !wave_q.a)
    else $error("clear on match failed");
  fast_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && is_fast && com_a == 2'b10 && at_top && !match[0] && !wr_cnt |=> wave_q.a)
    else $error("fast pwm set at top failed");
  chan_b_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !is_up && com_b == 2'b01 && !wr_cnt |=> $stable(wave_q.b))
    else $error("chan B toggled in pwm");
endmodule : timer16_waveform_mode_control

// *** wave_load.sv ***
`timescale 1ns/1ps
// ==========
// Load on the two waveform pins, pulled low while not driven
module wave_load (
  // Device pins
  input  wire logic               wave_out_a,
  input  wire logic               wave_out_a_oe,
  input  wire logic               wave_out_b,
  input  wire logic               wave_out_b_oe,
  // Level seen by the load
  output timer16_pkg::wave_pair_t pin
);
  assign pin = {wave_out_a_oe & wave_out_a, wave_out_b_oe & wave_out_b};
endmodule : wave_load

// *** timer16_waveform_mode_control_bench.sv ***
`timescale 1ns/1ps
`include "timer16_cfg.svh"
// ==========
// Bench for the waveform control block
module timer16_waveform_mode_control_bench;
  timer16_pkg::apb_req_t   req = '0;
  timer16_pkg::wave_pair_t pin;
  logic                    pclk = 1'b0;
  logic                    presetn = 1'b0;
  logic                    ext_clk_pin = 1'b0;
  logic [31:0]             prdata;
  logic                    pready, pslverr, irq;
  logic                    wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
  logic [31:0]             r;
  logic                    e;
  int                      err_count = 0;
  int                      check_count = 0;
  int                      dv[5] = '{1, 8, 64, 256, 1024};

  always #5 pclk = ~pclk;

  timer16_waveform_mode_control timer16_waveform_mode_control_i (
    .pclk(pclk), .presetn(presetn), .psel(req.psel), .penable(req.penable),
    .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
    .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b),
    .wave_out_b_oe(wave_out_b_oe), .irq(irq));

  wave_load wave_load_i (
    .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b),
    .wave_out_b_oe(wave_out_b_oe), .pin(pin));

  // ==========
  // Bus tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rv, output logic ev);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    req <= '0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rv;
    logic        ev;
    apb(1'b1, a, d, rv, ev);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] rv);
    logic ev;
    apb(1'b0, a, 32'h0, rv, ev);
  endtask : rd

  // ==========
  // Compare tasks
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  // Configure, settle, then count high cycles of one pin over 512 cycles
  task automatic row(input logic [7:0] ca, input logic [7:0] cb, input logic [15:0] ma,
                     input logic [15:0] mb, input logic [15:0] cp, input bit sel,
                     input int lo, input int hi);
    int n;
    logic p;
    wr(`T16_CTRL_B_ADDR, 32'h0);
    wr(`T16_CMP_A_ADDR, {16'h0, ma});
    wr(`T16_CMP_B_ADDR, {16'h0, mb});
    wr(`T16_CAPT_ADDR, {16'h0, cp});
    wr(`T16_COUNT_ADDR, 32'h0);
    wr(`T16_CTRL_A_ADDR, {24'h0, ca});
    wr(`T16_CTRL_B_ADDR, {24'h0, cb});
    repeat (600) @(posedge pclk);
    n = 0;
    repeat (512) begin
      @(posedge pclk);
      p = sel ? pin.b : pin.a;
      n += $isunknown(p) ? 100000 : int'(p);
    end
    chk_rng("duty", lo, hi, n);
  endtask : row

  task automatic final_report();
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    final_report();
  end

  // ==========
  // Tests
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`T16_CTRL_A_ADDR, r);
    chk("ctrl_a", 32'h0, r);
    wr(`T16_CTRL_A_ADDR, 32'hFF);
    rd(`T16_CTRL_A_ADDR, r);
    chk("ctrl_a", 32'hF3, r);
    wr(`T16_CTRL_B_ADDR, 32'hFF);
    rd(`T16_CTRL_B_ADDR, r);
    chk("ctrl_b", 32'h1F, r);
    apb(1'b0, 12'h024, 32'h0, r, e);
    chk("unmapped", 32'h1, {31'h0, e});
    wr(`T16_PORT_ADDR, 32'hF);
    row(8'h41, 8'h09, 16'h80, 16'h0, 16'h0, 0, 512, 512);
    row(8'h53, 8'h19, 16'h0F, 16'h0, 16'h0, 0, 240, 272);
    row(8'h53, 8'h19, 16'h0F, 16'h0, 16'h0, 1, 512, 512);
    row(8'h81, 8'h09, 16'hFF, 16'h0, 16'h0, 0, 512, 512);
    row(8'hC1, 8'h09, 16'hFF, 16'h0, 16'h0, 0, 0, 0);
    row(8'h81, 8'h09, 16'h40, 16'h0, 16'h0, 0, 120, 140);
    row(8'h82, 8'h19, 16'h10, 16'h0, 16'h3F, 0, 126, 146);
    row(8'h41, 8'h01, 16'h80, 16'h0, 16'h0, 0, 512, 512);
    row(8'h81, 8'h01, 16'h80, 16'h0, 16'h0, 0, 240, 272);
    row(8'h30, 8'h11, 16'h0, 16'h10, 16'h40, 1, 370, 400);
    row(8'h41, 8'h11, 16'h20, 16'h0, 16'h0, 0, 220, 292);
    row(8'h43, 8'h11, 16'h20, 16'h0, 16'h0, 0, 220, 292);
    row(8'hC0, 8'h09, 16'h20, 16'h0, 16'h0, 0, 512, 512);
    row(8'h80, 8'h09, 16'h20, 16'h0, 16'h0, 0, 0, 0);
    row(8'hC1, 8'h19, 16'h20, 16'h0, 16'h0, 0, 0, 0);
    row(8'h40, 8'h09, 16'h20, 16'h0, 16'h0, 0, 220, 292);
    wr(`T16_PORT_ADDR, 32'h3);
    chk("oe_a", 32'h0, {31'h0, wave_out_a_oe});
    chk("pin_a", 32'h0, {31'h0, pin.a});
    wr(`T16_CTRL_B_ADDR, 32'h0);
    wr(`T16_CTRL_A_ADDR, 32'h0);
    wr(`T16_MASK_ADDR, 32'h0);
    wr(`T16_STATUS_ADDR, 32'h7);
    wr(`T16_COUNT_ADDR, 32'hFFF0);
    wr(`T16_CTRL_B_ADDR, 32'h1);
    repeat (40) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(`T16_STATUS_ADDR, r);
    chk("overflow", 32'h1, {31'h0, r[0]});
    wr(`T16_MASK_ADDR, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`T16_STATUS_ADDR, 32'h1);
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`T16_CTRL_B_ADDR, 32'h0);
    wr(`T16_COUNT_ADDR, 32'h1234);
    repeat (20) @(posedge pclk);
    rd(`T16_COUNT_ADDR, r);
    chk("stopped", 32'h1234, r);
    foreach (dv[i]) begin
      wr(`T16_CTRL_B_ADDR, i + 1);
      wr(`T16_COUNT_ADDR, 32'h0);
      repeat (dv[i] * 10) @(posedge pclk);
      rd(`T16_COUNT_ADDR, r);
      chk_rng("prescale", 9, 16, r);
    end
    for (int cs = 6; cs < 8; cs++) begin
      wr(`T16_CTRL_B_ADDR, cs);
      wr(`T16_COUNT_ADDR, 32'h0);
      repeat (4) begin
        ext_clk_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_clk_pin <= 1'b0;
        repeat (4) @(posedge pclk);
      end
      rd(`T16_COUNT_ADDR, r);
      chk("ext_count", 32'h4, r);
    end
    final_report();
  end
endmodule : timer16_waveform_mode_control_bench
